/* bench/pcg_board_model.sv */
/*
 * Board circuitry on the eight configurable pads.
 * Assumes the board drives each pad only while the device leaves it undriven.
 */
`timescale 1ns/1ns
module pcg_board_model (
    // Device side
    input  wire pcg_pkg::pcg_pad_drive_s pad_drive,
    // Board side
    input  wire logic [7:0]              board_level,
    output logic      [7:0]              pad_level
);
    // Board yields wherever the device drives, so no contention
    assign pad_level = (pad_drive.oe & pad_drive.value) | (~pad_drive.oe & board_level);
endmodule // pcg_board_model

/* bench/tb_top.sv */
/*
 * Self-checking bench of the pin configuration block.
 * Assumes pcg_pkg, pcg_top and pcg_board_model are compiled before it.
 */
`timescale 1ns/1ns
module tb_top;
    logic                    clk;
    logic                    reset_n;
    pcg_pkg::pcg_reg_req_s   req;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    scan_on;
    logic                    clk_func;
    logic                    tdo_v;
    logic                    tdo_oe;
    pcg_pkg::pcg_sig_src_s   src;
    logic [7:0]              pad_lvl;
    logic [7:0]              ext;
    pcg_pkg::pcg_pad_drive_s drive;
    logic                    tpin;
    logic                    tpin_oe;
    logic                    fast;
    logic [31:0]             seed;
    int                      miscompares;
    int                      total_checks;
    wire logic [15:0]        pads_seen = {drive.oe, drive.value & drive.oe};
    wire logic [15:0]        tpin_seen = {14'h0, tpin_oe, tpin & tpin_oe};

    pcg_top DUT (.clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rdata_q(rdata),
        .reg_rvalid_q(rvalid), .boundary_scan_active(scan_on), .clock_output_func(clk_func),
        .scan_tdo_value(tdo_v), .scan_tdo_oe(tdo_oe), .sig_src(src), .pad_in(pad_lvl),
        .pad_drive_q(drive), .test_signal_pin_q(tpin), .test_signal_pin_oe_q(tpin_oe),
        .fast_pad_switching_q(fast));
    pcg_board_model board (.pad_drive(drive), .board_level(ext), .pad_level(pad_lvl));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [15:0] exp_pads(input logic [7:0] en, input logic [7:0] val,
                                             input logic scan, input logic cf,
                                             input logic tv, input logic to);
        logic [7:0] oe;
        logic [7:0] v;
        oe = en;
        v  = val;
        if (!en[6]) begin
            oe[6] = 1'b1;
            v[6]  = cf;
        end
        if (scan) begin
            oe[3:0] = {3'b000, to};
            v[0]    = tv;
        end
        return {oe, v & oe};
    endfunction

    function automatic logic [1:0] exp_tpin(input logic [3:0] sel, input logic [5:0] s);
        if (sel == 4'h2) return 2'b10;
        if (sel == 4'h3) return 2'b11;
        if (sel >= 4'h4 && sel <= 4'h9) return {1'b1, s[4'h9 - sel]};
        return 2'b00;
    endfunction

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.wr_en <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr_en <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
        int n;
        @(posedge clk);
        req.rd_en <= 1'b1;
        req.addr  <= a;
        @(posedge clk);
        req.rd_en <= 1'b0;
        n = 0;
        #1;
        while (rvalid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 4) begin
            miscompares++;
            conclude();
        end else begin
            check({8'h00, rdata}, {8'h00, e}, what);
        end
    endtask

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        conclude();
    end

    initial begin
        logic [31:0] r;
        logic [7:0]  en;
        logic [7:0]  val;
        logic [7:0]  sel;
        logic [15:0] ep;
        reset_n = 1'b0;
        req = '0;
        scan_on = 1'b0;
        clk_func = 1'b0;
        tdo_v = 1'b0;
        tdo_oe = 1'b0;
        src = '0;
        ext = 8'h00;
        seed = 32'hd97c79b3;
        miscompares = 0;
        total_checks = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        ep = exp_pads(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        check(pads_seen, ep, "pads");
        rd_chk(8'h44, 8'h00, "enable after reset");
        rd_chk(8'h45, 8'h00, "value after reset");
        rd_chk(8'h47, 8'h00, "select after reset");
        rd_chk(8'h48, 8'h00, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 48; i++) begin
            seed = xorshift(seed);
            en  = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
            val = seed[15:8];
            sel = {seed[23:20], i[3:0]};
            r   = xorshift(seed);
            seed = r;
            @(posedge clk);
            scan_on  <= r[24] | (i == 1);
            clk_func <= r[25];
            tdo_v    <= r[26];
            tdo_oe   <= r[27];
            src      <= r[5:0];
            ext      <= r[15:8];
            reg_write(8'h44, en);
            reg_write(8'h45, val);
            reg_write(8'h46, ~en);
            reg_write(8'h47, sel);
            reg_write(8'h43, 8'hff);
            repeat (5) @(posedge clk);
            #1;
            ep = exp_pads(en, val, scan_on, clk_func, tdo_v, tdo_oe);
            check(pads_seen, ep, "pad drive");
            check(tpin_seen, {14'h0, exp_tpin(sel[3:0], src)}, "tpin");
            check({15'h0, fast}, {15'h0, sel[7]}, "pad speed");
            rd_chk(8'h44, en, "enable readback");
            rd_chk(8'h45, val, "value readback");
            rd_chk(8'h47, sel & 8'h8f, "select readback");
            rd_chk(8'h46, (ep[15:8] & ep[7:0]) | (~ep[15:8] & ext), "pad levels");
        end
        $display("test random sweep done");
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        ep = exp_pads(8'h00, 8'h00, scan_on, clk_func, tdo_v, tdo_oe);
        check(pads_seen, ep, "pads after mid-run reset");
        check(tpin_seen, 16'h0000, "tpin after mid-run reset");
        check({15'h0, fast}, 16'h0000, "pad speed after mid-run reset");
        rd_chk(8'h44, 8'h00, "enable after mid-run reset");
        rd_chk(8'h45, 8'h00, "value after mid-run reset");
        rd_chk(8'h47, 8'h00, "select after mid-run reset");
        $display("test mid-run reset done");
        conclude();
    end
endmodule // tb_top

/* rtl/pcg_sync.sv */
/*
 * Two-flop synchroniser, one stage pair per bit.
 * Assumes inputs are asynchronous pad levels; only the second stage is used.
 */
`timescale 1ns/1ns
module pcg_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta_q[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_q[i]   <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule // pcg_sync

/* rtl/pcg_top.sv */
/*
 * Pin configuration: GPIO takeover of multi-function pins, pad speed and
 * test signal routing, with byte-wide host registers at 44h..47h.
 * Assumes the host interface decoder delivers single-cycle read and write
 * strobes on clk, and that function sources come from logic on clk.
 */
// Notes on behaviour
// (RQ1) Enable bit 7 turns the signal-input pin into a driven GPIO.
// (RQ2) Enable bit 6 turns the clock-output pin into GPIO and drops its clock function.
// (RQ3) Enable bits 5 and 4 drive the two interface-select pins as GPIO.
// (RQ4) Enable bits 3..0 drive the scan pins as GPIO unless boundary scan is configured on.
// (RQ5) Register 45h holds the pin output values, same mapping, fully read/write.
// (RQ6) Register 46h reads back the sampled pin levels, same mapping.
// (RQ7) Register 47h has pad speed at bit 7, reserved 6..4, and a 4-bit select in 3..0.
// (RQ8) A pin whose enable bit is clear is never driven from the value register.
// (RQ9) The select field routes tri-state, 0, 1 or an internal signal to the test pin.
// (RQ10) The pad speed bit switches the pads to fast switching.
`timescale 1ns/1ns
`include "pcg_params.svh"
module pcg_top (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Host register access
    input  wire pcg_pkg::pcg_reg_req_s reg_req,
    output logic [7:0]                 reg_rdata_q,
    output logic                       reg_rvalid_q,
    // Dedicated functions
    input  wire logic                  boundary_scan_active,
    input  wire logic                  clock_output_func,
    input  wire logic                  scan_tdo_value,
    input  wire logic                  scan_tdo_oe,
    input  wire pcg_pkg::pcg_sig_src_s sig_src,
    // Configurable pads, bit order 7..0 as in the enable register
    input  wire logic [7:0]            pad_in,
    output pcg_pkg::pcg_pad_drive_s    pad_drive_q,
    // Test signal pad and pad speed
    output logic                       test_signal_pin_q,
    output logic                       test_signal_pin_oe_q,
    output logic                       fast_pad_switching_q
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] pin_output_enable_q;
    logic [7:0] pin_output_value_q;
    logic [7:0] test_signal_select_q;
    logic [7:0] pin_input_level;

    wire logic hit_enable = reg_req.addr == `PCG_ADDR_PIN_OUTPUT_ENABLE;
    wire logic hit_value  = reg_req.addr == `PCG_ADDR_PIN_OUTPUT_VALUE;
    wire logic hit_level  = reg_req.addr == `PCG_ADDR_PIN_INPUT_LEVEL;
    wire logic hit_select = reg_req.addr == `PCG_ADDR_TEST_SIGNAL_SELECT;

    // Reserved bits never stored, so they always read zero
    wire logic [7:0] select_wmask = ~`PCG_RSVD_MASK;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_output_enable_q  <= `PCG_RST_OUTPUT_ENABLE;
            pin_output_value_q   <= `PCG_RST_OUTPUT_VALUE;
            test_signal_select_q <= `PCG_RST_TEST_SELECT;
        end else if (reg_req.wr_en) begin
            if (hit_enable) pin_output_enable_q  <= reg_req.wdata;
            if (hit_value) pin_output_value_q    <= reg_req.wdata;                 // [RQ5]
            if (hit_select) test_signal_select_q <= reg_req.wdata & select_wmask;  // [RQ7]
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Writes to the level register are ignored; unmapped reads give zero
    wire logic [7:0] rdata_d = hit_enable ? pin_output_enable_q  :
                               hit_value  ? pin_output_value_q   :
                               hit_level  ? pin_input_level      :  // [RQ6]
                               hit_select ? test_signal_select_q :  // [RQ7]
                                            `PCG_RDATA_NONE;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q  <= `PCG_RDATA_NONE;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_req.rd_en;
            if (reg_req.rd_en) reg_rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Pad input sampling
    // ------------------------------------------------------------------
    pcg_sync #(
        .WIDTH    (8)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (pad_in),
        .sync_out (pin_input_level)
    );

    // ------------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------------
    // Scan enables masked while boundary scan owns the pins
    wire logic [3:0] func_en = pin_output_enable_q[`PCG_BIT_SIGNAL_INPUT:`PCG_BIT_IFACE_SEL_A];
    wire logic [3:0] scan_en = pin_output_enable_q[`PCG_BIT_SCAN_HI:`PCG_BIT_SCAN_TDO];
    wire logic [7:0] gpio_en = {func_en, scan_en & {4{~boundary_scan_active}}};  // [RQ1] [RQ3] [RQ4]

    wire logic clk_func = ~pin_output_enable_q[`PCG_BIT_CLOCK_OUTPUT];             // [RQ2]
    wire logic tdo_func = boundary_scan_active;

    // Pins not enabled fall back to their function or stay input
    wire logic [7:0] fn_oe  = {1'b0, clk_func, 5'b0_0000, tdo_func & scan_tdo_oe};
    wire logic [7:0] fn_val = {1'b0, clk_func & clock_output_func, 5'b0_0000,
                               tdo_func & scan_tdo_value};

    pcg_pkg::pcg_pad_drive_s drive_d;
    assign drive_d.oe    = gpio_en | fn_oe;                                         // [RQ8]
    assign drive_d.value = (gpio_en & pin_output_value_q) | (~gpio_en & fn_val);    // [RQ8]

    // ------------------------------------------------------------------
    // Test signal routing
    // ------------------------------------------------------------------
    wire logic [3:0] sel = test_signal_select_q[`PCG_SEL_HI:`PCG_SEL_LO];
    logic test_val_d;
    logic test_oe_d;

    always_comb begin
        test_oe_d  = 1'b1;
        test_val_d = 1'b0;
        case (sel)                                                                  // [RQ9]
            `PCG_SEL_LOW:     test_val_d = 1'b0;
            `PCG_SEL_HIGH:    test_val_d = 1'b1;
            `PCG_SEL_TX_ENV:  test_val_d = sig_src.tx_envelope;
            `PCG_SEL_TX_ACT:  test_val_d = sig_src.tx_active;
            `PCG_SEL_GENERIC: test_val_d = sig_src.generic;
            `PCG_SEL_RX_ENV:  test_val_d = sig_src.rx_envelope;
            `PCG_SEL_RX_ACT:  test_val_d = sig_src.rx_active;
            `PCG_SEL_RX_BIT:  test_val_d = sig_src.rx_bit;
            // Codes 0, 1 and unused codes leave the pin floating
            default:          test_oe_d  = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_drive_q          <= '0;
            test_signal_pin_q    <= 1'b0;
            test_signal_pin_oe_q <= 1'b0;
            fast_pad_switching_q <= 1'b0;
        end else begin
            pad_drive_q          <= drive_d;
            test_signal_pin_q    <= test_val_d;
            test_signal_pin_oe_q <= test_oe_d;
            // Fast mode raises peak supply current when many pads toggle
            fast_pad_switching_q <= test_signal_select_q[`PCG_BIT_FAST_PAD];        // [RQ10]
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_SIG_INPUT_DRIVE: assert property ( // [RQ1]
        ##1 pad_drive_q.oe[7] == $past(pin_output_enable_q[7]))
        else $error("Signal-input pin enable does not follow its enable bit");

    AST_CLOCK_PIN_GPIO: assert property ( // [RQ2]
        pin_output_enable_q[6] |=> pad_drive_q.oe[6]
                                   && pad_drive_q.value[6] == $past(pin_output_value_q[6]))
        else $error("Clock-output pin not acting as GPIO");

    AST_CLOCK_PIN_FUNC: assert property ( // [RQ2]
        !pin_output_enable_q[6] |=> pad_drive_q.value[6] == $past(clock_output_func))
        else $error("Clock-output function not on pin");

    AST_IFACE_SEL_DRIVE: assert property ( // [RQ3]
        ##1 pad_drive_q.oe[5:4] == $past(pin_output_enable_q[5:4]))
        else $error("Interface-select drive does not follow enable bits");

    AST_SCAN_LOCK: assert property ( // [RQ4]
        boundary_scan_active |=> pad_drive_q.oe[3:1] == 3'b000)
        else $error("Scan pins driven while boundary scan active");

    AST_VALUE_WRITE: assert property ( // [RQ5]
        reg_req.wr_en && hit_value |=> pin_output_value_q == $past(reg_req.wdata))
        else $error("Output value register not written");

    AST_LEVEL_READ: assert property ( // [RQ6]
        reg_req.rd_en && hit_level |=> reg_rvalid_q && reg_rdata_q == $past(pin_input_level))
        else $error("Level read does not return sampled pins");

    AST_RSVD_ZERO: assert property ( // [RQ7]
        reg_req.rd_en && hit_select |=> reg_rdata_q[6:4] == 3'b000)
        else $error("Reserved select bits read nonzero");

    AST_NO_STRAY_DRIVE: assert property ( // [RQ8]
        !pin_output_enable_q[5] ##1 !pin_output_enable_q[5] |-> !pad_drive_q.oe[5])
        else $error("Disabled pin driven");

    AST_TEST_LOW: assert property ( // [RQ9]
        sel == `PCG_SEL_LOW |=> test_signal_pin_oe_q && !test_signal_pin_q)
        else $error("Test pin not driven low for code 2");

    AST_TEST_TRI: assert property ( // [RQ9]
        sel == `PCG_SEL_TRI1 |=> !test_signal_pin_oe_q)
        else $error("Test pin not floating for code 1");

    AST_TEST_HIGH: assert property ( // [RQ9]
        sel == `PCG_SEL_HIGH |=> test_signal_pin_oe_q && test_signal_pin_q)
        else $error("Test pin not driven high for code 3");

    AST_SCAN_TDO_OWNER: assert property ( // [RQ4]
        boundary_scan_active |=> pad_drive_q.oe[`PCG_BIT_SCAN_TDO] == $past(scan_tdo_oe))
        else $error("Scan data pin drive not owned by scan logic");

    AST_FAST_PAD: assert property ( // [RQ10]
        $rose(test_signal_select_q[7]) |=> fast_pad_switching_q)
        else $error("Pad speed not applied");

endmodule // pcg_top

/* shared/pcg_params.svh */
/*
 * Offsets, field positions, reset values and select codes of the pin
 * configuration block.
 * Assumes inclusion by bare name from any file that needs the constants.
 */
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PCG_ADDR_PIN_OUTPUT_ENABLE  8'h44
`define PCG_ADDR_PIN_OUTPUT_VALUE   8'h45
`define PCG_ADDR_PIN_INPUT_LEVEL    8'h46
`define PCG_ADDR_TEST_SIGNAL_SELECT 8'h47

// ----------------------------------------------------------------------
// Bit positions shared by enable, value and level registers
// ----------------------------------------------------------------------
`define PCG_BIT_SIGNAL_INPUT        7
`define PCG_BIT_CLOCK_OUTPUT        6
`define PCG_BIT_IFACE_SEL_B         5
`define PCG_BIT_IFACE_SEL_A         4
`define PCG_BIT_SCAN_HI             3
`define PCG_BIT_SCAN_TDI            1
`define PCG_BIT_SCAN_TDO            0

// ----------------------------------------------------------------------
// Test signal select register fields
// ----------------------------------------------------------------------
`define PCG_BIT_FAST_PAD            7
`define PCG_SEL_HI                  3
`define PCG_SEL_LO                  0
`define PCG_RSVD_MASK               8'h70

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCG_RST_OUTPUT_ENABLE       8'h00
`define PCG_RST_OUTPUT_VALUE        8'h00
`define PCG_RST_TEST_SELECT         8'h00
`define PCG_RDATA_NONE              8'h00

// ----------------------------------------------------------------------
// Test signal source codes
// ----------------------------------------------------------------------
`define PCG_SEL_TRI0                4'h0
`define PCG_SEL_TRI1                4'h1
`define PCG_SEL_LOW                 4'h2
`define PCG_SEL_HIGH                4'h3
`define PCG_SEL_TX_ENV              4'h4
`define PCG_SEL_TX_ACT              4'h5
`define PCG_SEL_GENERIC             4'h6
`define PCG_SEL_RX_ENV              4'h7
`define PCG_SEL_RX_ACT              4'h8
`define PCG_SEL_RX_BIT              4'h9

`endif

/* shared/pcg_pkg.sv */
/*
 * Types of the pin configuration block.
 * Assumes pcg_params.svh supplies the numeric constants.
 */
package pcg_pkg;

    // Drive of the eight configurable pads
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] value;
    } pcg_pad_drive_s;

    // Internal sources that can be routed to the test signal pin
    typedef struct packed {
        logic tx_envelope;
        logic tx_active;
        logic generic;
        logic rx_envelope;
        logic rx_active;
        logic rx_bit;
    } pcg_sig_src_s;

    // Host register access request
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcg_reg_req_s;

endpackage
